// File: src/btib_pkg.sv
/*
  Constants of the base timer with interrupt and buzzer outputs.
  Assumes a single clock domain and an AHB-Lite register bus.
*/
package btib_pkg;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_INPUT_SIGNAL_SELECT = 16'hfe5f;
  localparam logic [15:0] IDX_BASE_TIMER_CONTROL  = 16'hfe7f;
  localparam logic [15:0] IDX_IRQ_STATUS          = 16'hfe80;
  localparam logic [15:0] IDX_IRQ_MASK            = 16'hfe81;
  localparam logic [15:0] IDX_COUNT               = 16'hfe82;

  // Reset values
  localparam logic [7:0] RST_INPUT_SIGNAL_SELECT = 8'h00;
  localparam logic [7:0] RST_BASE_TIMER_CONTROL  = 8'h00;
  localparam logic [1:0] RST_IRQ                 = 2'h0;

  // Fields of base_timer_control
  localparam int BIT_INT0_FAST_PERIOD_SEL = 7;
  localparam int BIT_TIMER_RUN_CTRL       = 6;
  localparam int BIT_INT1_PERIOD_SEL_HI   = 5;
  localparam int BIT_INT1_PERIOD_SEL_LO   = 4;
  localparam int BIT_INT1_FLAG            = 3;
  localparam int BIT_INT1_ENABLE          = 2;
  localparam int BIT_INT0_FLAG            = 1;
  localparam int BIT_INT0_ENABLE          = 0;

  // Fields of input_signal_select
  localparam int BIT_CLK_SOURCE_SEL_HI = 5;
  localparam int BIT_CLK_SOURCE_SEL_LO = 4;
  localparam int BIT_BUZZER_ENABLE     = 3;

  // Clock source codes
  localparam logic [1:0] CLK_SRC_CYCLE = 2'h1;
  localparam logic [1:0] CLK_SRC_T0PS  = 2'h3;

  // Status and mask bits
  localparam int BIT_EVT_INT0 = 0;
  localparam int BIT_EVT_INT1 = 1;

  // Count register: bit that clears the counters on write
  localparam int BIT_COUNT_CLEAR = 0;

  // Counter widths
  localparam int LOW_W = 8;
  localparam int HIGH_W = 6;
  localparam int CNT_W = LOW_W + HIGH_W;

  // Period exponents: a period of 2**k input clocks
  localparam int K_INT0_SLOW = 14;
  localparam int K_INT0_FAST = 6;
  localparam int K_INT1_S00 = 5;
  localparam int K_INT1_S01 = 7;
  localparam int K_INT1_S10 = 9;
  localparam int K_INT1_S11 = 11;
  localparam int K_INT1_F10 = 1;
  localparam int K_INT1_F11 = 3;

  // Buzzer divides the input clock by 16: output is count bit 3
  localparam int BIT_BUZZER_TAP = 3;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
endpackage

// File: src/btib_tick_sel.sv
/*
  Input clock selector of the base timer: one-cycle tick per input clock.
  Assumes the timer 0 prescaler pulse is synchronous to hclk.
*/
module btib_tick_sel
  import btib_pkg::*;
(
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       ce,
  // Selection
  input  wire logic [1:0] src_sel,
  input  wire logic       t0_prescale_tick,
  // Tick out
  output logic            tick
);
  logic next_tick;

  always_comb begin
    case (src_sel)
      CLK_SRC_CYCLE: next_tick = 1'b1;
      CLK_SRC_T0PS:  next_tick = t0_prescale_tick;
      default:       next_tick = 1'b0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick <= 1'b0;
    end else if (ce) begin
      tick <= next_tick;
    end
  end
endmodule // btib_tick_sel

// File: src/btib_top.sv
/*
  Base timer: 14-bit counter, two periodic interrupt flags, buzzer.
  Assumes an AHB-Lite master with single word transfers on hclk.
*/
// What this block does
// - Slow mode int1 period 32/128/512/2048 clocks
// - Int1 flag sets each period, sticky
// - Int0 flag sets each period, sticky
// - Int1 flag and enable request vector
// - Int0 flag and enable request vector
// - Rewriting int1 period code may set flag
// - Clock select 01 cycle, 11 prescaler
// - Buzzer enabled drives input clock / 16
// - Buzzer disabled holds output low
// - 8-bit counter carries into 6-bit, clearable
// - Run bit 0 stops timer at zero
module btib_top
  import btib_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Timer input
  input  wire logic        t0_prescale_tick,
  // Outputs
  output logic             buzzer_pin,
  output logic             vector_req,
  output logic             irq
);
  // Control and state
  logic [7:0]        base_timer_control;
  logic [7:0]        next_base_timer_control;
  logic [7:0]        input_signal_select;
  logic [7:0]        next_input_signal_select;
  logic [1:0]        irq_status;
  logic [1:0]        next_irq_status;
  logic [1:0]        irq_mask;
  logic [1:0]        next_irq_mask;
  logic [CNT_W-1:0]  count;
  logic [CNT_W-1:0]  next_count;
  logic              buzzer_q;
  logic              next_buzzer;
  logic              vector_q;
  logic              next_vector;
  logic              irq_q;
  logic              next_irq;

  // Bus state
  logic              wr_pend;
  logic              next_wr_pend;
  logic [15:0]       wr_idx;
  logic [15:0]       next_wr_idx;
  logic [31:0]       rdata_q;
  logic [31:0]       next_rdata;

  // Helpers
  logic              tick;
  logic              advance;
  logic              evt0;
  logic              evt1;
  logic              acc;
  logic              addr_ok;
  logic [15:0]       acc_idx;
  logic              rd_status;
  logic              wr_btc;
  logic              wr_isl;
  logic              wr_mask;
  logic              wr_cnt;
  logic [7:0]        wd;
  logic [1:0]        src_sel;

  // True when the low k bits of a value are all zero
  function automatic logic low_zero(input logic [CNT_W-1:0] v,
                                    input int k);
    logic z;
    z = 1'b1;
    for (int i = 0; i < CNT_W; i++) begin
      if (i < k && v[i]) begin
        z = 1'b0;
      end
    end
    return z;
  endfunction

  // Period exponent of interrupt 1
  function automatic int int1_k(input logic fast, input logic [1:0] sel);
    int k;
    k = K_INT1_S00;
    case ({fast, sel})
      3'b000:  k = K_INT1_S00;
      3'b001:  k = K_INT1_S01;
      3'b010:  k = K_INT1_S10;
      3'b011:  k = K_INT1_S11;
      3'b100:  k = K_INT1_S00;
      3'b101:  k = K_INT1_S01;
      3'b110:  k = K_INT1_F10;
      3'b111:  k = K_INT1_F11;
      default: k = K_INT1_S00;
    endcase
    return k;
  endfunction

  assign src_sel = {input_signal_select[BIT_CLK_SOURCE_SEL_HI],
                    input_signal_select[BIT_CLK_SOURCE_SEL_LO]};

  btib_tick_sel u_tick_sel (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .ce               (ce),
    .src_sel          (src_sel),
    .t0_prescale_tick (t0_prescale_tick),
    .tick             (tick)
  );

  // Address phase decode
  assign acc = hsel && hready &&
               (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign acc_idx = haddr[17:2];
  assign addr_ok = (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'h0);
  assign rd_status = acc && !hwrite && addr_ok &&
                     (acc_idx == IDX_IRQ_STATUS);

  // Data phase write strobes
  assign wd = hwdata[7:0];
  assign wr_btc  = wr_pend && (wr_idx == IDX_BASE_TIMER_CONTROL);
  assign wr_isl  = wr_pend && (wr_idx == IDX_INPUT_SIGNAL_SELECT);
  assign wr_mask = wr_pend && (wr_idx == IDX_IRQ_MASK);
  assign wr_cnt  = wr_pend && (wr_idx == IDX_COUNT);

  // Bus slave
  always_comb begin
    next_wr_pend = 1'b0;
    next_wr_idx  = wr_idx;
    next_rdata   = rdata_q;
    if (acc) begin
      next_wr_pend = hwrite && addr_ok;
      next_wr_idx  = acc_idx;
      next_rdata   = 32'h0000_0000;
      if (!hwrite && addr_ok) begin
        case (acc_idx)
          IDX_BASE_TIMER_CONTROL:
            next_rdata = {24'h00_0000, base_timer_control};
          IDX_INPUT_SIGNAL_SELECT:
            next_rdata = {24'h00_0000, input_signal_select};
          IDX_IRQ_STATUS: next_rdata = {30'h0000_0000, irq_status};
          IDX_IRQ_MASK:   next_rdata = {30'h0000_0000, irq_mask};
          IDX_COUNT:      next_rdata = {18'h0_0000, count};
          default:        next_rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wr_idx    <= 16'h0000;
      rdata_q   <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ce) begin
      wr_pend   <= next_wr_pend;
      wr_idx    <= next_wr_idx;
      rdata_q   <= next_rdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign hrdata = rdata_q;

  // Counter
  always_comb begin
    advance    = tick && (base_timer_control[BIT_TIMER_RUN_CTRL] ||
                          count != '0);
    next_count = count;
    evt0       = 1'b0;
    evt1       = 1'b0;
    if (advance) begin
      // Low byte carries into the upper six bits
      next_count[LOW_W-1:0] = count[LOW_W-1:0] + 8'h01;
      if (count[LOW_W-1:0] == 8'hff) begin
        next_count[CNT_W-1:LOW_W] =
          count[CNT_W-1:LOW_W] + 6'h01;
      end
      evt1 = low_zero(next_count,
               int1_k(base_timer_control[BIT_INT0_FAST_PERIOD_SEL],
                      base_timer_control[BIT_INT1_PERIOD_SEL_HI:
                                         BIT_INT1_PERIOD_SEL_LO]));
      evt0 = low_zero(next_count,
               base_timer_control[BIT_INT0_FAST_PERIOD_SEL] ?
               K_INT0_FAST : K_INT0_SLOW);
    end
    if (wr_cnt && hwdata[BIT_COUNT_CLEAR]) begin
      next_count = '0;
    end
  end

  // Control registers and flags
  always_comb begin
    next_base_timer_control  = base_timer_control;
    next_input_signal_select = input_signal_select;
    next_irq_mask            = irq_mask;
    if (wr_isl) begin
      next_input_signal_select = wd;
    end
    if (wr_mask) begin
      next_irq_mask = hwdata[1:0];
    end
    if (wr_btc) begin
      next_base_timer_control[7:4] = wd[7:4];
      next_base_timer_control[BIT_INT1_ENABLE] = wd[BIT_INT1_ENABLE];
      next_base_timer_control[BIT_INT0_ENABLE] = wd[BIT_INT0_ENABLE];
      if (!wd[BIT_INT1_FLAG]) begin
        next_base_timer_control[BIT_INT1_FLAG] = 1'b0;
      end
      if (!wd[BIT_INT0_FLAG]) begin
        next_base_timer_control[BIT_INT0_FLAG] = 1'b0;
      end
      if (wd[5:4] != base_timer_control[5:4]) begin
        next_base_timer_control[BIT_INT1_FLAG] = 1'b1;
      end
    end
    // Period events win over a clearing write
    if (evt1) begin
      next_base_timer_control[BIT_INT1_FLAG] = 1'b1;
    end
    if (evt0) begin
      next_base_timer_control[BIT_INT0_FLAG] = 1'b1;
    end
  end

  // Sticky status, cleared by a read, events win
  always_comb begin
    next_irq_status = rd_status ? 2'h0 : irq_status;
    if (evt0) begin
      next_irq_status[BIT_EVT_INT0] = 1'b1;
    end
    if (evt1) begin
      next_irq_status[BIT_EVT_INT1] = 1'b1;
    end
    next_irq = |(next_irq_status & next_irq_mask);
    next_vector =
      (next_base_timer_control[BIT_INT1_FLAG] &&
       next_base_timer_control[BIT_INT1_ENABLE]) ||
      (next_base_timer_control[BIT_INT0_FLAG] &&
       next_base_timer_control[BIT_INT0_ENABLE]);
    next_buzzer = next_input_signal_select[BIT_BUZZER_ENABLE] &&
                  next_count[BIT_BUZZER_TAP];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      base_timer_control  <= RST_BASE_TIMER_CONTROL;
      input_signal_select <= RST_INPUT_SIGNAL_SELECT;
      irq_status          <= RST_IRQ;
      irq_mask            <= RST_IRQ;
      count               <= '0;
      buzzer_q            <= 1'b0;
      vector_q            <= 1'b0;
      irq_q               <= 1'b0;
    end else if (ce) begin
      base_timer_control  <= next_base_timer_control;
      input_signal_select <= next_input_signal_select;
      irq_status          <= next_irq_status;
      irq_mask            <= next_irq_mask;
      count               <= next_count;
      buzzer_q            <= next_buzzer;
      vector_q            <= next_vector;
      irq_q               <= next_irq;
    end
  end

  assign buzzer_pin = buzzer_q;
  assign vector_req = vector_q;
  assign irq        = irq_q;
endmodule // btib_top

// File: tb/btib_chk.sv
/*
  Port checker of btib_top, bound to every instance.
  Assumes one bus slave, so hready is the slave's hreadyout.
*/
module btib_chk
  import btib_pkg::*;
(
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Timer
  input wire logic        t0_prescale_tick,
  input wire logic        buzzer_pin,
  input wire logic        vector_req,
  input wire logic        irq
);
  localparam logic [31:0] A_ISL  = {14'h0, IDX_INPUT_SIGNAL_SELECT, 2'h0};
  localparam logic [31:0] A_STAT = {14'h0, IDX_IRQ_STATUS, 2'h0};
  logic       acc, map, tk, isl_q, buz, next_isl, next_buz;
  logic [1:0] src, next_src;
  logic [2:0] quiet, tq, next_quiet, next_tq;
  assign acc = hsel && hready && htrans[1];
  assign map = haddr[1:0] == 2'h0 && haddr[31:18] == 14'h0 &&
    haddr[17:2] inside {IDX_INPUT_SIGNAL_SELECT, IDX_BASE_TIMER_CONTROL,
    IDX_IRQ_STATUS, IDX_IRQ_MASK, IDX_COUNT};
  assign tk = src == CLK_SRC_CYCLE ||
    (src == CLK_SRC_T0PS && t0_prescale_tick);
  // Mirror of clock source and buzzer enable, cycles since activity
  always_comb begin
    next_isl = acc && hwrite && haddr == A_ISL;
    next_src = src;
    next_buz = buz;
    if (isl_q) begin
      next_src = hwdata[5:4];
      next_buz = hwdata[3];
    end
    next_quiet = (acc || tk) ? 3'h0 : quiet + 3'(quiet != 3'h7);
    next_tq = tk ? 3'h0 : tq + 3'(tq != 3'h7);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {isl_q, buz, src, quiet, tq} <= '0;
    end else begin
      {isl_q, buz, src} <= {next_isl, next_buz, next_src};
      {quiet, tq} <= {next_quiet, next_tq};
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_s;
    acc && !hwrite;
  endsequence
  sequence stat_rd_s;
    acc && !hwrite && haddr == A_STAT && tq == 3'h7 ##1 (tq != 3'h0) [*3];
  endsequence
  resp_okay_a: assert property (!hresp) else $error("hresp not okay");
  ready_high_a: assert property (hreadyout) else $error("wait state");
  read_upper_a: assert property (rd_s |=> hrdata[31:14] == 18'h0)
    else $error("dead read bits set");
  unmapped_zero_a: assert property (rd_s and !map |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  buzz_quiet_a: assert property (quiet == 3'h7 |-> $stable(buzzer_pin))
    else $error("buzzer moved without tick");
  vec_quiet_a: assert property (quiet == 3'h7 |-> $stable(vector_req))
    else $error("vector moved without tick");
  irq_quiet_a: assert property (quiet == 3'h7 |-> $stable(irq))
    else $error("irq moved without tick");
  buzz_off_a: assert property (!buz && !$past(buz) |-> !buzzer_pin)
    else $error("buzzer high while off");
  stat_clear_a: assert property (stat_rd_s |-> !irq)
    else $error("irq kept after status read");
endmodule // btib_chk

bind btib_top btib_chk chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
  .t0_prescale_tick, .buzzer_pin, .vector_req, .irq);

// File: tb/btib_top_tb.sv
/*
  Self-checking bench of btib_top with a period model.
  Assumes a zero-wait slave and a prescaler tick synchronous to hclk.
*/
module btib_top_tb
  import btib_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk, hresetn, hsel, hwrite, t0;
  logic        hreadyout, hresp, buzzer_pin, vector_req, irq;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] lfsr;
  int          error_cnt, checks, prev, n;

  btib_top dut (.hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .t0_prescale_tick(t0), .buzzer_pin,
    .vector_req, .irq);

  initial begin
    hclk = 0;
    forever #10 hclk = ~hclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic xfer(input logic w, input logic [15:0] idx,
                      input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {14'h0, idx, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Holds the prescaler tick for k cycles, then lets the pipe settle
  task automatic ticks(input int k);
    @(posedge hclk);
    t0 <= 1;
    repeat (k) @(posedge hclk);
    t0 <= 0;
    repeat (8) @(posedge hclk);
  endtask

  function automatic int period(int f, int c, int i0);
    if (i0) return f ? 64 : 16384;
    if (f && c >= 2) return c == 2 ? 2 : 8;
    return 32 << (2 * c);
  endfunction

  task automatic per(input int f, input int c, input int i0);
    logic [7:0] ctl;
    ctl = {f[0], 1'b1, c[1:0], 1'b0, ~i0[0], 1'b0, i0[0]};
    n = period(f, c, i0);
    xfer(1, IDX_BASE_TIMER_CONTROL, ctl);
    xfer(0, IDX_BASE_TIMER_CONTROL, 0);
    chk(rd[3], c != prev);
    prev = c;
    xfer(1, IDX_COUNT, 1);
    xfer(1, IDX_BASE_TIMER_CONTROL, {24'h00_0000, ctl & 8'hf5});
    xfer(1, IDX_IRQ_MASK, i0 ? 1 : 2);
    xfer(0, IDX_IRQ_STATUS, 0);
    ticks(n - 1);
    chk(vector_req, 0);
    chk(irq, 0);
    chk(buzzer_pin, (n - 1) >> 3 & 1);
    ticks(1);
    chk(vector_req, 1);
    chk(irq, 1);
    chk(buzzer_pin, n >> 3 & 1);
    xfer(0, IDX_IRQ_STATUS, 0);
    chk(rd[!i0], 1);
    repeat (2) @(posedge hclk);
    chk(irq, 0);
    $display("period test f=%0d c=%0d i0=%0d done", f, c, i0);
  endtask

  initial begin
    {hsel, hwrite, t0, hresetn} = 0;
    htrans = 0;
    haddr = 0;
    hwdata = 0;
    prev = 0;
    lfsr = 16'd43359;
    repeat (20) @(posedge hclk);
    hresetn <= 1;
    xfer(0, IDX_INPUT_SIGNAL_SELECT, 0);
    chk(rd, RST_INPUT_SIGNAL_SELECT);
    xfer(0, IDX_BASE_TIMER_CONTROL, 0);
    chk(rd, RST_BASE_TIMER_CONTROL);
    xfer(0, 16'h0100, 0);
    chk(rd, 0);
    $display("register test done");
    xfer(1, IDX_INPUT_SIGNAL_SELECT, 32'h0000_0038);
    for (int i = 0; i < 8; i++) per(i[2], i[1:0], 0);
    per(1, 0, 1);
    per(0, 0, 1);
    xfer(1, IDX_BASE_TIMER_CONTROL, 0);
    xfer(1, IDX_COUNT, 1);
    ticks(5);
    xfer(0, IDX_COUNT, 0);
    chk(rd, 0);
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    n = 300 + lfsr[7:0];
    xfer(1, IDX_BASE_TIMER_CONTROL, 32'h0000_0040);
    ticks(n);
    xfer(0, IDX_COUNT, 0);
    chk(rd, n);
    xfer(1, IDX_BASE_TIMER_CONTROL, 0);
    ticks(16384 - n + 7);
    xfer(0, IDX_COUNT, 0);
    chk(rd, 0);
    xfer(1, IDX_BASE_TIMER_CONTROL, 32'h0000_0040);
    xfer(1, IDX_INPUT_SIGNAL_SELECT, 32'h0000_0030);
    ticks(8);
    chk(buzzer_pin, 0);
    $display("count test done");
    print_verdict;
  end

  initial begin
    repeat (60000) @(posedge hclk);
    error_cnt++;
    print_verdict;
  end
endmodule // btib_top_tb
